// ### core/reset_source_controller.v
// Behaviour
// - Power-on clears program counter after start delay
// - Power-on sets port data, direction to ones
// - Selected reset pin low resets, restarts at zero
// - Extra delay after reset pin returns high
// - Function code 55 I/O, AA pin, else reset
// - Bad function code: delayed reset, set flag
// - Function register restores 55 except warm timeout
// - Reset pin selection overrides other pin sharing
// - Control corruption flag: hardware sets, software clears
// - Low supply longer than width resets, sets flag
// - Width code selects 8/32/64/128 period filter
// - Threshold codes decode four levels or disable
// - Bad threshold code: delayed reset, restore value
// - Genuine low supply reset keeps threshold code
// - Threshold register powers up as 55
// - Low supply detection off in power down
// - Threshold corruption flag set; software clears flags
// - Normal watchdog timeout resets, sets timeout flag
// - Power-down timeout clears PC, SP; sets flags
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "reset_source_defines.vh"

module reset_source_controller #(
    parameter ADDR_W = 8,
    parameter [15:0] LIRC_DIV = `LIRC_DIV_CYCLES,
    parameter [15:0] RSTD_TICKS = `RSTD_TICKS,
    parameter [15:0] SRESET_TICKS = `SRESET_TICKS
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [ADDR_W-1:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire external_reset_pin_n,
    input wire supply_low,
    input wire watchdog_overflow,
    input wire power_down_mode,
    input wire halt_exec,
    input wire clear_watchdog,
    output reg core_reset_q,
    output reg port_preset_q,
    output reg pc_sp_clear_q,
    output reg reset_pin_selected_q,
    output reg [1:0] threshold_level_q,
    output reg monitor_enable_q,
    output reg watchdog_timeout_flag_q,
    output reg power_down_flag_q
);
    // Sequencer states
    localparam [1:0] ST_RUN = 2'h0;
    localparam [1:0] ST_HOLD = 2'h1;
    localparam [1:0] ST_EXTEND = 2'h2;

    reg [1:0] state_q; // Sequencer state
    reg [15:0] ext_cnt_q; // Low-speed periods of extension
    reg [15:0] div_cnt_q; // Low-speed divider
    reg lirc_tick_q; // One-cycle low-speed enable
    reg [7:0] reset_function_control_q; // Shared pin role
    reg [7:0] threshold_code_q; // Supply threshold select
    reg [1:0] min_low_width_code_q; // Filter width select
    reg control_corruption_reset_flag_q; // Sticky
    reg low_supply_reset_flag_q; // Sticky
    reg threshold_corruption_reset_flag_q; // Sticky
    reg pend_ctrl_q; // Corrupt function code waiting
    reg pend_thr_q; // Corrupt threshold code waiting
    reg [15:0] sreset_cnt_q; // Software-reset delay count
    reg aw_full_q; // Write address held
    reg w_full_q; // Write data held
    reg [ADDR_W-1:0] aw_addr_q;
    reg [7:0] w_byte_q; // Only the low lane is implemented
    reg w_lane_q; // Low lane strobe
    reg [1:0] thr_level;
    reg thr_valid;
    reg thr_disable;
    reg [31:0] rd_word;
    reg rd_hit;
    wire supply_trip; // Valid low supply drop
    wire ctrl_bad;
    wire pin_reset;
    wire sreset_fire;
    wire full_reset;
    wire wdt_normal;
    wire wdt_warm;
    wire wr_go;
    wire wr_hit;
    wire wr_ctrl;
    wire wr_flags;
    wire wr_thr;
    wire wr_width;

    // Threshold decode
    always @* begin
        thr_valid = 1'b1;
        thr_disable = 1'b0;
        case (threshold_code_q)
            `THR_CODE_1V90: thr_level = 2'h0;
            `THR_CODE_2V20: thr_level = 2'h1;
            `THR_CODE_2V55: thr_level = 2'h2;
            `THR_CODE_3V15: thr_level = 2'h3;
            `THR_CODE_DISABLE: begin
                thr_level = 2'h0;
                thr_disable = 1'b1;
            end
            default: begin
                thr_level = 2'h0;
                thr_valid = 1'b0;
            end
        endcase
    end

    // Function code
    assign ctrl_bad = (reset_function_control_q != `FUNC_CODE_IO) &&
                      (reset_function_control_q != `FUNC_CODE_RESET_PIN);
    // Pin acts only while the reset role is selected
    assign pin_reset = (reset_function_control_q == `FUNC_CODE_RESET_PIN) && !external_reset_pin_n;
    assign sreset_fire = (pend_ctrl_q || pend_thr_q) && lirc_tick_q &&
                         (sreset_cnt_q == SRESET_TICKS - 16'h0001);
    assign wdt_normal = watchdog_overflow && !power_down_mode && (state_q == ST_RUN);
    assign wdt_warm = watchdog_overflow && power_down_mode && (state_q == ST_RUN);
    // Any reset that restores the registers
    assign full_reset = (state_q == ST_RUN) && (pin_reset || supply_trip || sreset_fire || wdt_normal);

    // Low-speed period enable divider
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_q <= 16'h0000;
            lirc_tick_q <= 1'b0;
        end else if (div_cnt_q == LIRC_DIV - 16'h0001) begin
            div_cnt_q <= 16'h0000;
            lirc_tick_q <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 16'h0001;
            lirc_tick_q <= 1'b0;
        end
    end

    // Width filter on the supply comparator
    lv_width_filter u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .lirc_tick(lirc_tick_q),
        .monitor_enable(monitor_enable_q),
        .supply_low(supply_low),
        .min_low_width_code(min_low_width_code_q),
        .trip_q(supply_trip)
    );

    // Analog-side controls; detection off in power down
    always @(posedge aclk) begin
        if (!aresetn) begin
            monitor_enable_q <= 1'b0;
            threshold_level_q <= 2'h0;
            reset_pin_selected_q <= 1'b0;
        end else begin
            monitor_enable_q <= thr_valid && !thr_disable && !power_down_mode;
            threshold_level_q <= thr_level;
            // Overrides the port's own sharing select
            reset_pin_selected_q <= (reset_function_control_q == `FUNC_CODE_RESET_PIN);
        end
    end

    // Software-reset delay for corrupted codes; latched once seen
    always @(posedge aclk) begin
        if (!aresetn || full_reset) begin
            pend_ctrl_q <= 1'b0;
            pend_thr_q <= 1'b0;
            sreset_cnt_q <= 16'h0000;
        end else begin
            if (ctrl_bad) begin
                pend_ctrl_q <= 1'b1;
            end
            if (!thr_valid) begin
                pend_thr_q <= 1'b1;
            end
            if ((pend_ctrl_q || pend_thr_q) && lirc_tick_q) begin
                sreset_cnt_q <= sreset_cnt_q + 16'h0001;
            end
        end
    end

    // Reset sequencer: hold while the pin is low (pin resets only), then extend before release
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_EXTEND; // Power-on start delay
            ext_cnt_q <= 16'h0000;
            core_reset_q <= 1'b1;
            port_preset_q <= 1'b1;
            pc_sp_clear_q <= 1'b0;
        end else begin
            pc_sp_clear_q <= wdt_warm; // Warm reset touches only PC and SP
            case (state_q)
                ST_RUN: begin
                    if (full_reset) begin
                        state_q <= pin_reset ? ST_HOLD : ST_EXTEND;
                        ext_cnt_q <= 16'h0000;
                        core_reset_q <= 1'b1;
                        port_preset_q <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    // Normal operation inhibited while pin is low
                    ext_cnt_q <= 16'h0000;
                    // Raw pin: the reset has already put the function code back to I/O
                    if (external_reset_pin_n) begin
                        state_q <= ST_EXTEND;
                    end
                end
                ST_EXTEND: begin
                    if (pin_reset) begin
                        state_q <= ST_HOLD;
                    end else if (lirc_tick_q) begin
                        if (ext_cnt_q == RSTD_TICKS - 16'h0001) begin
                            state_q <= ST_RUN; // Execution restarts at zero
                            core_reset_q <= 1'b0;
                            port_preset_q <= 1'b0;
                        end else begin
                            ext_cnt_q <= ext_cnt_q + 16'h0001;
                        end
                    end
                end
                default: begin
                    state_q <= ST_EXTEND;
                    ext_cnt_q <= 16'h0000;
                    core_reset_q <= 1'b1;
                    port_preset_q <= 1'b1;
                end
            endcase
        end
    end

    // Bus write path: address and data taken in either order
    assign awready = !aw_full_q && !bvalid;
    assign wready = !w_full_q && !bvalid;
    assign wr_go = aw_full_q && w_full_q && !bvalid;
    assign wr_ctrl = wr_go && w_lane_q && (aw_addr_q[7:2] == `OFS_RESET_FUNCTION_CONTROL >> 2);
    assign wr_flags = wr_go && w_lane_q && (aw_addr_q[7:2] == `OFS_RESET_SOURCE_FLAGS >> 2);
    assign wr_thr = wr_go && w_lane_q && (aw_addr_q[7:2] == `OFS_LOW_VOLTAGE_THRESHOLD_SELECT >> 2);
    assign wr_width = wr_go && w_lane_q && (aw_addr_q[7:2] == `OFS_LOW_VOLTAGE_WIDTH_SELECT >> 2);
    assign wr_hit = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q <= `OFS_CORE_STATUS);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= {ADDR_W{1'b0}};
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                w_byte_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Guarded configuration registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            reset_function_control_q <= `RSTVAL_FUNCTION_CONTROL;
            threshold_code_q <= `RSTVAL_THRESHOLD_SELECT;
            min_low_width_code_q <= `RSTVAL_WIDTH_CODE;
        end else if (full_reset) begin
            // Warm timeout never reaches here, so it keeps them
            reset_function_control_q <= `RSTVAL_FUNCTION_CONTROL;
            min_low_width_code_q <= `RSTVAL_WIDTH_CODE;
            // Genuine low supply keeps the threshold code
            if (!(supply_trip && !pin_reset)) begin
                threshold_code_q <= `RSTVAL_THRESHOLD_SELECT;
            end
        end else begin
            if (wr_ctrl) begin
                reset_function_control_q <= w_byte_q;
            end
            if (wr_thr) begin
                threshold_code_q <= w_byte_q;
            end
            if (wr_width) begin
                min_low_width_code_q <= w_byte_q[1:0];
            end
        end
    end

    // Sticky source flags: software may write 0 only; a set wins over a clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            control_corruption_reset_flag_q <= 1'b0;
            low_supply_reset_flag_q <= 1'b0;
            threshold_corruption_reset_flag_q <= 1'b0;
        end else begin
            if (sreset_fire && pend_ctrl_q && (state_q == ST_RUN) && !pin_reset && !supply_trip) begin
                control_corruption_reset_flag_q <= 1'b1;
            end else if (wr_flags && !w_byte_q[`FLAG_BIT_CONTROL_CORRUPT]) begin
                control_corruption_reset_flag_q <= 1'b0;
            end
            if (supply_trip && (state_q == ST_RUN) && !pin_reset) begin
                low_supply_reset_flag_q <= 1'b1;
            end else if (wr_flags && !w_byte_q[`FLAG_BIT_LOW_SUPPLY]) begin
                low_supply_reset_flag_q <= 1'b0;
            end
            if (sreset_fire && pend_thr_q && (state_q == ST_RUN) && !pin_reset && !supply_trip) begin
                threshold_corruption_reset_flag_q <= 1'b1;
            end else if (wr_flags && !w_byte_q[`FLAG_BIT_THRESHOLD_CORRUPT]) begin
                threshold_corruption_reset_flag_q <= 1'b0;
            end
        end
    end

    // Timeout and power-down flags; pin and supply resets leave them alone
    always @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_timeout_flag_q <= 1'b0;
            power_down_flag_q <= 1'b0;
        end else if (wdt_warm) begin
            watchdog_timeout_flag_q <= 1'b1;
            power_down_flag_q <= 1'b1;
        end else if (wdt_normal && !pin_reset && !supply_trip && !sreset_fire) begin
            watchdog_timeout_flag_q <= 1'b1;
        end else if (clear_watchdog) begin
            watchdog_timeout_flag_q <= 1'b0;
            power_down_flag_q <= 1'b0;
        end else if (halt_exec) begin
            watchdog_timeout_flag_q <= 1'b0;
            power_down_flag_q <= 1'b1;
        end
    end

    // Read mux; unimplemented bits read as zero
    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (araddr[7:0])
            `OFS_RESET_FUNCTION_CONTROL: rd_word[7:0] = reset_function_control_q;
            `OFS_RESET_SOURCE_FLAGS: begin
                rd_word[`FLAG_BIT_CONTROL_CORRUPT] = control_corruption_reset_flag_q;
                rd_word[`FLAG_BIT_LOW_SUPPLY] = low_supply_reset_flag_q;
                rd_word[`FLAG_BIT_THRESHOLD_CORRUPT] = threshold_corruption_reset_flag_q;
            end
            `OFS_LOW_VOLTAGE_THRESHOLD_SELECT: rd_word[7:0] = threshold_code_q;
            `OFS_LOW_VOLTAGE_WIDTH_SELECT: rd_word[1:0] = min_low_width_code_q;
            `OFS_CORE_STATUS: begin
                rd_word[`STAT_BIT_TIMEOUT] = watchdog_timeout_flag_q;
                rd_word[`STAT_BIT_POWER_DOWN] = power_down_flag_q;
                rd_word[`STAT_BIT_CORE_RESET] = core_reset_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // Bus read path: one cycle to the answer
    assign arready = !rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// ### pkg/reset_source_defines.vh
`ifndef RESET_SOURCE_DEFINES_VH
`define RESET_SOURCE_DEFINES_VH

// Register byte offsets
`define OFS_RESET_FUNCTION_CONTROL 8'h00
`define OFS_RESET_SOURCE_FLAGS 8'h04
`define OFS_LOW_VOLTAGE_THRESHOLD_SELECT 8'h08
`define OFS_LOW_VOLTAGE_WIDTH_SELECT 8'h0C
`define OFS_CORE_STATUS 8'h10

// Reset values
`define RSTVAL_FUNCTION_CONTROL 8'h55
`define RSTVAL_THRESHOLD_SELECT 8'h55
`define RSTVAL_WIDTH_CODE 2'h1

// Shared pin role codes
`define FUNC_CODE_IO 8'h55
`define FUNC_CODE_RESET_PIN 8'hAA

// Threshold codes
`define THR_CODE_1V90 8'h55
`define THR_CODE_2V20 8'h33
`define THR_CODE_2V55 8'h99
`define THR_CODE_3V15 8'hAA
`define THR_CODE_DISABLE 8'hF0

// Flag bit positions in reset_source_flags
`define FLAG_BIT_CONTROL_CORRUPT 3
`define FLAG_BIT_LOW_SUPPLY 2
`define FLAG_BIT_THRESHOLD_CORRUPT 1

// Bit positions in core_status
`define STAT_BIT_TIMEOUT 0
`define STAT_BIT_POWER_DOWN 1
`define STAT_BIT_CORE_RESET 2

// Minimum low width in low-speed periods, per code
`define WIDTH_TICKS_0 8'h08
`define WIDTH_TICKS_1 8'h20
`define WIDTH_TICKS_2 8'h40
`define WIDTH_TICKS_3 8'h80

// Low-speed oscillator timing at a 100 MHz core clock
`define LIRC_DIV_CYCLES 16'h0C35 // 31250 ns period over a 10 ns clock

// Delays in low-speed periods
`define RSTD_TICKS 16'h0010
`define SRESET_TICKS 16'h0010

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### core/lv_width_filter.v
`timescale 1ns/10ps
`include "reset_source_defines.vh"

// Ignores supply dips shorter than the selected minimum width
module lv_width_filter (
    input wire aclk,
    input wire aresetn,
    input wire lirc_tick, // One-cycle low-speed enable
    input wire monitor_enable, // Detection allowed
    input wire supply_low, // Comparator below threshold
    input wire [1:0] min_low_width_code, // Width select
    output reg trip_q // One-cycle pulse: valid low supply
);
    reg [7:0] low_cnt_q; // Low-speed periods spent low
    reg [7:0] limit; // Periods needed for a valid drop

    // Width lookup
    always @* begin
        case (min_low_width_code)
            2'h0: limit = `WIDTH_TICKS_0;
            2'h1: limit = `WIDTH_TICKS_1;
            2'h2: limit = `WIDTH_TICKS_2;
            default: limit = `WIDTH_TICKS_3;
        endcase
    end

    // Count whole periods; the partial first period gives the (N-1~N) window
    always @(posedge aclk) begin
        if (!aresetn) begin
            low_cnt_q <= 8'h00;
            trip_q <= 1'b0;
        end else if (!(monitor_enable && supply_low)) begin
            // Any return above threshold restarts the width
            low_cnt_q <= 8'h00;
            trip_q <= 1'b0;
        end else if (lirc_tick && (low_cnt_q == limit - 8'h01)) begin
            low_cnt_q <= 8'h00;
            trip_q <= 1'b1;
        end else begin
            if (lirc_tick) begin
                low_cnt_q <= low_cnt_q + 8'h01;
            end
            trip_q <= 1'b0;
        end
    end
endmodule

// ### bench/ext_reset_circuit.sv
`timescale 1ns/10ps
// Pull-up plus switch on the shared reset pin
module ext_reset_circuit (
    input wire aclk,
    input wire pin_go, // Close the switch
    input wire [7:0] pin_len, // Cycles held low
    output logic external_reset_pin_n
);
    logic [7:0] left_q = 8'h00; // Remaining low cycles
    // Pull-up wins whenever the switch is open
    assign external_reset_pin_n = (left_q == 8'h00);
    // Count down the press, no bounce modelled
    always @(posedge aclk) begin
        if (pin_go) begin
            left_q <= pin_len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
endmodule

// ### bench/reset_source_controller_sva.sv
`timescale 1ns/10ps
module reset_source_controller_sva (
    input wire aclk,
    input wire aresetn,
    input wire external_reset_pin_n,
    input wire watchdog_overflow,
    input wire power_down_mode,
    input wire reset_pin_selected_q,
    input wire core_reset_q,
    input wire port_preset_q,
    input wire pc_sp_clear_q,
    input wire monitor_enable_q,
    input wire watchdog_timeout_flag_q,
    input wire power_down_flag_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Start-delay and extension checks are lower bounds only, so they hold for any longer delay
    property p_preset; port_preset_q == core_reset_q; endproperty
    a_preset: assert property (p_preset) else $error("port preset differs from core reset");
    property p_por; $rose(aresetn) |-> core_reset_q [*4]; endproperty
    a_por: assert property (p_por) else $error("start delay too short");
    property p_pin; !external_reset_pin_n && !core_reset_q && reset_pin_selected_q |=> core_reset_q;
    endproperty
    a_pin: assert property (p_pin) else $error("pin low did not reset");
    property p_ext; $rose(external_reset_pin_n) && core_reset_q |-> core_reset_q [*4]; endproperty
    a_ext: assert property (p_ext) else $error("pin extension too short");
    property p_wdt; watchdog_overflow && !power_down_mode && !core_reset_q
        |-> ##[1:3] (core_reset_q && watchdog_timeout_flag_q); endproperty
    a_wdt: assert property (p_wdt) else $error("timeout reset missing");
    property p_warm; watchdog_overflow && power_down_mode && !core_reset_q
        |=> pc_sp_clear_q && watchdog_timeout_flag_q && power_down_flag_q && !core_reset_q; endproperty
    a_warm: assert property (p_warm) else $error("warm reset wrong");
    property p_pcsp; pc_sp_clear_q |-> $past(watchdog_overflow) && $past(power_down_mode); endproperty
    a_pcsp: assert property (p_pcsp) else $error("stray pc clear");
    property p_sleep; power_down_mode && $past(power_down_mode) |-> !monitor_enable_q; endproperty
    a_sleep: assert property (p_sleep) else $error("monitor on in power down");
    c_warm: cover property (pc_sp_clear_q);
    c_pin: cover property (!external_reset_pin_n && core_reset_q);
    c_wdt: cover property (watchdog_timeout_flag_q && core_reset_q);
endmodule
bind reset_source_controller reset_source_controller_sva u_reset_source_controller_sva (.aclk, .aresetn,
    .external_reset_pin_n, .watchdog_overflow, .power_down_mode, .core_reset_q, .port_preset_q,
    .pc_sp_clear_q, .reset_pin_selected_q, .monitor_enable_q, .watchdog_timeout_flag_q, .power_down_flag_q);

// ### bench/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb_top;
    logic aclk = 0, aresetn = 0, supply_low = 0, power_down_mode = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, pin_len = 8'h14;
    logic [31:0] wdata = 0, got;
    logic [3:0] wstrb = 4'hF, ev = 0; // Event pulses
    logic [1:0] resp;
    logic [7:0] codes [5] = '{8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
    wire watchdog_overflow = ev[0], halt_exec = ev[1], clear_watchdog = ev[2], pin_go = ev[3];
    wire awready, wready, bvalid, arready, rvalid, core_reset_q, port_preset_q, pc_sp_clear_q;
    wire reset_pin_selected_q, monitor_enable_q, watchdog_timeout_flag_q, power_down_flag_q;
    wire external_reset_pin_n;
    wire [1:0] bresp, rresp, threshold_level_q;
    wire [31:0] rdata;
    int failures = 0, tests_run = 0, cyc = 0;
    // Short low-speed period keeps the run small
    reset_source_controller #(.LIRC_DIV(16'h0004), .RSTD_TICKS(16'h0002), .SRESET_TICKS(16'h0002))
    u_reset_source_controller (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .external_reset_pin_n, .supply_low, .watchdog_overflow, .power_down_mode, .halt_exec,
        .clear_watchdog, .core_reset_q, .port_preset_q, .pc_sp_clear_q, .reset_pin_selected_q,
        .threshold_level_q, .monitor_enable_q, .watchdog_timeout_flag_q, .power_down_flag_q);
    ext_reset_circuit u_ext_reset_circuit (.aclk, .pin_go, .pin_len, .external_reset_pin_n);
    always #5 aclk = ~aclk;
    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Ready is read at the negedge, where it equals its value at the next edge
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw && w)) begin
            @(negedge aclk);
            if (awvalid && awready) aw = 1;
            if (wvalid && wready) w = 1;
            @(posedge aclk);
            if (aw) awvalid <= 0;
            if (w) wvalid <= 0;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge aclk);
        bready <= 0;
    endtask
    task automatic bus_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        got = rdata;
        resp = rresp;
        if (er == 2'h0) `CHK("rdata", e, got)
        `CHK("rresp", er, resp)
        @(posedge aclk);
        rready <= 0;
    endtask
    task automatic wait_core(input logic lvl);
        int n;
        n = 0;
        while (core_reset_q !== lvl && n < 400) begin
            @(negedge aclk);
            n++;
        end
        `CHK("core_reset_q", lvl, core_reset_q)
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= 4'h0;
    endtask
    task automatic dip(input int n);
        @(posedge aclk);
        supply_low <= 1;
        repeat (n) @(posedge aclk);
        supply_low <= 0;
        repeat (2) @(negedge aclk);
        `CHK("core_reset_q", 1'b0, core_reset_q)
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        wait_core(1'b0);
        `CHK("port_preset_q", 1'b0, port_preset_q)
        bus_read(8'h00, 32'h55, 2'h0);
        bus_read(8'h04, 32'h00, 2'h0);
        bus_read(8'h08, 32'h55, 2'h0);
        bus_read(8'h0C, 32'h01, 2'h0);
        bus_read(8'h14, 32'h00, 2'h2);
        bus_write(8'h14, 8'h01);
        `CHK("bresp", 2'h2, resp)
        // Every threshold code, disable last
        for (int i = 0; i < 5; i++) begin
            bus_write(8'h08, codes[i]);
            @(negedge aclk);
            if (i < 4) `CHK("threshold_level_q", i[1:0], threshold_level_q)
            else `CHK("monitor_enable_q", 1'b0, monitor_enable_q)
        end
        // Corrupt threshold code
        bus_write(8'h08, 8'h12);
        wait_core(1'b1);
        wait_core(1'b0);
        bus_read(8'h04, 32'h02, 2'h0);
        bus_read(8'h08, 32'h55, 2'h0);
        bus_write(8'h04, 8'h00);
        bus_read(8'h04, 32'h00, 2'h0);
        // Corrupt function code, flag ignores writes of one
        bus_write(8'h00, 8'h3C);
        wait_core(1'b1);
        wait_core(1'b0);
        bus_read(8'h04, 32'h08, 2'h0);
        bus_read(8'h00, 32'h55, 2'h0);
        bus_write(8'h04, 8'hFF);
        bus_read(8'h04, 32'h08, 2'h0);
        bus_write(8'h04, 8'h00);
        bus_read(8'h04, 32'h00, 2'h0);
        // Reset pin press
        bus_write(8'h00, 8'hAA);
        @(negedge aclk);
        `CHK("reset_pin_selected_q", 1'b1, reset_pin_selected_q)
        pulse(4'h8);
        wait_core(1'b1);
        wait_core(1'b0);
        bus_read(8'h00, 32'h55, 2'h0);
        bus_read(8'h04, 32'h00, 2'h0);
        // Dips just short of the window, then a real drop
        dip(124);
        bus_write(8'h0C, 8'h00);
        bus_write(8'h08, 8'h33);
        dip(28);
        @(posedge aclk);
        supply_low <= 1;
        wait_core(1'b1);
        @(posedge aclk);
        supply_low <= 0;
        wait_core(1'b0);
        bus_read(8'h04, 32'h04, 2'h0);
        bus_read(8'h08, 32'h33, 2'h0);
        bus_read(8'h0C, 32'h01, 2'h0);
        bus_write(8'h04, 8'h00);
        // Watchdog in normal run
        pulse(4'h1);
        wait_core(1'b1);
        wait_core(1'b0);
        bus_read(8'h10, 32'h01, 2'h0);
        pulse(4'h4);
        bus_read(8'h10, 32'h00, 2'h0);
        // Watchdog in power down keeps registers
        bus_write(8'h00, 8'hAA);
        @(posedge aclk);
        power_down_mode <= 1;
        repeat (3) @(negedge aclk);
        `CHK("monitor_enable_q", 1'b0, monitor_enable_q)
        pulse(4'h1);
        @(negedge aclk);
        `CHK("core_reset_q", 1'b0, core_reset_q)
        bus_read(8'h10, 32'h03, 2'h0);
        bus_read(8'h00, 32'hAA, 2'h0);
        pulse(4'h4);
        @(posedge aclk);
        power_down_mode <= 0;
        pulse(4'h2);
        bus_read(8'h10, 32'h02, 2'h0);
        // Second power-on in mid-run restores the function code
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        wait_core(1'b0);
        bus_read(8'h00, 32'h55, 2'h0);
        tally_and_finish();
    end
endmodule
